// ==== sep_eeprom.sv ====
// serial 16x16 nonvolatile memory: link shifter, programming control and array
`timescale 1ns/100ps
module sep_eeprom
(
    // system clock, enable and reset
    input wire logic mclk,
    input wire logic ce,
    input wire logic srst,
    // serial link
    input wire logic serialClockIn,
    input wire logic chipSelect,
    input wire logic serialIn,
    output logic serialOut,
    output logic serialOutEnN,
    // status
    output logic programVoltage,
    output logic lowPowerStandby
);

    // ************************************************************
    // declarations
    // ************************************************************
    logic linkRstMeta;
    logic linkRst;
    sep_pkg::sep_link_e linkState;
    logic armed;
    logic [4:0] bitCnt;
    logic [sep_pkg::INSTR_W-1:0] instr;
    logic [sep_pkg::INSTR_W-1:0] next_instr;
    logic [sep_pkg::WORD_W-1:0] dataSr;
    logic [sep_pkg::WORD_W-1:0] readSr;
    logic [sep_pkg::WORD_W-1:0] selWord;
    logic readDrive;
    logic readBit;
    logic addrLsb;
    logic [sep_pkg::PAIR_ADDR_W-1:0] pairAddr;
    logic reqToggle;
    logic ackMeta;
    logic ackSync;
    logic loadReady;
    logic cmdToggle;
    sep_pkg::sep_cmd_s cmdHold;
    logic opIsData;
    logic dataLast;

    logic reqMeta;
    logic reqSync;
    logic reqLast;
    logic cmdMeta;
    logic cmdSync;
    logic cmdLast;
    logic csMeta;
    logic csSync;
    logic ackToggle;
    logic rdEn;
    logic cmdEvent;
    logic isProgOp;
    logic progEnable;
    logic wrFire;
    sep_pkg::sep_prog_e progState;
    sep_pkg::sep_wr_s pendWr;
    sep_pkg::sep_wr_s memWr;
    sep_pkg::sep_wr_s next_pend;
    logic [2*sep_pkg::WORD_W-1:0] pairHold;

    // ************************************************************
    // link domain: reset crossing and instruction shifter
    // ************************************************************
    always_ff @(posedge serialClockIn)
    begin
        linkRstMeta <= srst;
        linkRst <= linkRstMeta;
    end

    assign next_instr = {instr[sep_pkg::INSTR_W-2:0], serialIn};
    assign opIsData = next_instr[7:6] == sep_pkg::OPHI_WRITE || next_instr[7:4] == sep_pkg::OP_WRITE_ALL;
    assign dataLast = linkState == sep_pkg::LK_DATA && bitCnt == sep_pkg::DATA_LAST_BIT;

    // chip select low ends any frame at once, even with the serial clock stopped; toggles survive it
    always_ff @(posedge serialClockIn or negedge chipSelect)
    begin
        if (!chipSelect)
        begin
            linkState <= sep_pkg::LK_IDLE;
            armed <= 1'b0;
            bitCnt <= 5'h00;
        end
        else if (linkRst)
        begin
            linkState <= sep_pkg::LK_IDLE;
            armed <= 1'b0;
            bitCnt <= 5'h00;
        end
        else
        begin
            armed <= 1'b1;
            case (linkState)
                sep_pkg::LK_IDLE:
                begin
                    if (armed && serialIn)
                    begin
                        linkState <= sep_pkg::LK_CMD;
                        bitCnt <= 5'h00;
                    end
                end
                sep_pkg::LK_CMD:
                begin
                    if (bitCnt == sep_pkg::CMD_LAST_BIT)
                    begin
                        bitCnt <= 5'h00;
                        if (next_instr[7:6] == sep_pkg::OPHI_READ)
                            linkState <= sep_pkg::LK_READ;
                        else if (opIsData)
                            linkState <= sep_pkg::LK_DATA;
                        else
                            linkState <= sep_pkg::LK_IDLE;
                    end
                    else
                        bitCnt <= bitCnt + 5'h01;
                end
                sep_pkg::LK_DATA:
                begin
                    if (bitCnt == sep_pkg::DATA_LAST_BIT)
                        linkState <= sep_pkg::LK_IDLE;
                    else
                        bitCnt <= bitCnt + 5'h01;
                end
                sep_pkg::LK_READ:
                begin
                    if (bitCnt == sep_pkg::READ_LAST_BIT)
                        linkState <= sep_pkg::LK_IDLE;
                    else if (bitCnt != sep_pkg::READ_LOAD_BIT || loadReady)
                        bitCnt <= bitCnt + 5'h01;
                end
                default:
                    linkState <= sep_pkg::LK_IDLE;
            endcase
        end
    end

    // instruction and data shift registers, most significant bit first
    always_ff @(posedge serialClockIn)
    begin
        if (linkRst)
        begin
            instr <= '0;
            dataSr <= '0;
            addrLsb <= 1'b0;
        end
        else if (linkState == sep_pkg::LK_CMD)
        begin
            instr <= next_instr;
            if (bitCnt == sep_pkg::CMD_LAST_BIT)
                addrLsb <= serialIn;
        end
        else if (linkState == sep_pkg::LK_DATA)
            dataSr <= {dataSr[sep_pkg::WORD_W-2:0], serialIn};
    end

    // read request goes out one bit early so the pair is back in time
    always_ff @(posedge serialClockIn)
    begin
        if (linkRst)
        begin
            reqToggle <= 1'b0;
            pairAddr <= '0;
        end
        else if (chipSelect && linkState == sep_pkg::LK_CMD && bitCnt == sep_pkg::CMD_PAIR_BIT
                 && next_instr[6:5] == sep_pkg::OPHI_READ)
        begin
            pairAddr <= next_instr[2:0];
            reqToggle <= ~reqToggle;
        end
    end

    // completed non-read instruction handed to the system domain
    always_ff @(posedge serialClockIn)
    begin
        if (linkRst)
        begin
            cmdToggle <= 1'b0;
            cmdHold <= '0;
        end
        else if (chipSelect && linkState == sep_pkg::LK_CMD && bitCnt == sep_pkg::CMD_LAST_BIT
                 && next_instr[7:6] != sep_pkg::OPHI_READ && !opIsData)
        begin
            cmdHold <= {next_instr, 16'h0000};
            cmdToggle <= ~cmdToggle;
        end
        else if (chipSelect && dataLast)
        begin
            cmdHold <= {instr, dataSr[sep_pkg::WORD_W-2:0], serialIn};
            cmdToggle <= ~cmdToggle;
        end
    end

    // ************************************************************
    // link domain: read output
    // ************************************************************
    always_ff @(posedge serialClockIn)
    begin
        ackMeta <= ackToggle;
        ackSync <= ackMeta;
    end

    assign loadReady = ackSync == reqToggle;
    assign selWord = addrLsb ? pairHold[sep_pkg::WORD_W-1:0] : pairHold[2*sep_pkg::WORD_W-1:sep_pkg::WORD_W];

    // a cut read must not drive again when chip select next rises
    always_ff @(posedge serialClockIn or negedge chipSelect)
    begin
        if (!chipSelect)
        begin
            readDrive <= 1'b0;
            readBit <= 1'b0;
            readSr <= '0;
        end
        else if (linkRst)
        begin
            readDrive <= 1'b0;
            readBit <= 1'b0;
            readSr <= '0;
        end
        else if (linkState == sep_pkg::LK_READ)
        begin
            if (bitCnt == sep_pkg::READ_DUMMY_BIT)
            begin
                readDrive <= 1'b1;
                readBit <= 1'b0;
            end
            else if (bitCnt == sep_pkg::READ_LOAD_BIT)
            begin
                if (loadReady)
                begin
                    readBit <= selWord[sep_pkg::WORD_W-1];
                    readSr <= {selWord[sep_pkg::WORD_W-2:0], 1'b0};
                end
            end
            else if (bitCnt == sep_pkg::READ_LAST_BIT)
                readDrive <= 1'b0;
            else
            begin
                readBit <= readSr[sep_pkg::WORD_W-1];
                readSr <= {readSr[sep_pkg::WORD_W-2:0], 1'b0};
            end
        end
    end

    assign serialOut = readBit;
    assign serialOutEnN = ~(readDrive & chipSelect);

    // ************************************************************
    // system domain: crossings
    // ************************************************************
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            reqMeta <= 1'b0;
            reqSync <= 1'b0;
            reqLast <= 1'b0;
            cmdMeta <= 1'b0;
            cmdSync <= 1'b0;
            cmdLast <= 1'b0;
            csMeta <= 1'b0;
            csSync <= 1'b0;
        end
        else if (ce)
        begin
            reqMeta <= reqToggle;
            reqSync <= reqMeta;
            reqLast <= reqSync;
            cmdMeta <= cmdToggle;
            cmdSync <= cmdMeta;
            cmdLast <= cmdSync;
            csMeta <= chipSelect;
            csSync <= csMeta;
        end
    end

    assign rdEn = reqSync != reqLast;
    assign cmdEvent = cmdSync != cmdLast;

    // ack echoes the request level in the edge that loads the pair
    always_ff @(posedge mclk)
    begin
        if (srst)
            ackToggle <= 1'b0;
        else if (ce && rdEn)
            ackToggle <= reqSync;
    end

    // ************************************************************
    // system domain: programming control
    // ************************************************************
    assign isProgOp = cmdHold.opcode[3:2] == sep_pkg::OPHI_WRITE || cmdHold.opcode[3:2] == sep_pkg::OPHI_ERASE
                      || cmdHold.opcode == sep_pkg::OP_ERASE_ALL || cmdHold.opcode == sep_pkg::OP_WRITE_ALL;

    always_comb
    begin
        next_pend.en = 1'b1;
        next_pend.all = cmdHold.opcode == sep_pkg::OP_ERASE_ALL || cmdHold.opcode == sep_pkg::OP_WRITE_ALL;
        next_pend.erase = cmdHold.opcode[3:2] == sep_pkg::OPHI_ERASE || cmdHold.opcode == sep_pkg::OP_ERASE_ALL;
        next_pend.addr = cmdHold.addr;
        next_pend.data = cmdHold.data;
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
            progEnable <= 1'b0;
        else if (ce && cmdEvent && cmdHold.opcode == sep_pkg::OP_PROG_ENABLE)
            progEnable <= 1'b1;
        else if (ce && cmdEvent && cmdHold.opcode == sep_pkg::OP_PROG_DISABLE)
            progEnable <= 1'b0;
    end

    // programming runs on the system clock since the serial clock may stop
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            progState <= sep_pkg::PG_IDLE;
            pendWr <= '0;
        end
        else if (ce)
        begin
            case (progState)
                sep_pkg::PG_IDLE:
                begin
                    if (cmdEvent && isProgOp && progEnable)
                    begin
                        progState <= sep_pkg::PG_ARMED;
                        pendWr <= next_pend;
                    end
                end
                sep_pkg::PG_ARMED:
                begin
                    if (!csSync)
                        progState <= sep_pkg::PG_BURN;
                    else if (cmdEvent && !(isProgOp && progEnable))
                        progState <= sep_pkg::PG_IDLE;
                    else if (cmdEvent)
                        pendWr <= next_pend;
                end
                sep_pkg::PG_BURN:
                begin
                    if (csSync)
                        progState <= sep_pkg::PG_IDLE;
                end
                default:
                    progState <= sep_pkg::PG_IDLE;
            endcase
        end
    end

    assign wrFire = ce && progState == sep_pkg::PG_ARMED && !csSync;

    always_comb
    begin
        memWr = pendWr;
        memWr.en = wrFire;
    end

    assign programVoltage = progState == sep_pkg::PG_BURN;
    assign lowPowerStandby = !csSync && progState == sep_pkg::PG_IDLE;

    sep_mem u_mem
    (
        .clk(mclk),
        .rst(srst),
        .ce(ce),
        .rdEn(rdEn),
        .rdPairAddr(pairAddr),
        .rdPair(pairHold),
        .wr(memWr)
    );

    // ************************************************************
    // checks
    // ************************************************************
    startGuard_a: assert property (@(posedge serialClockIn) disable iff (linkRst)
        linkState == sep_pkg::LK_IDLE && !armed |=> linkState == sep_pkg::LK_IDLE)
        else $error("start bit taken without a prior selected clock");
    outRelease_a: assert property (@(posedge serialClockIn) disable iff (linkRst)
        linkState != sep_pkg::LK_READ |-> serialOutEnN)
        else $error("serial output driven outside a read");
    dummyBit_a: assert property (@(posedge serialClockIn) disable iff (linkRst)
        chipSelect && linkState == sep_pkg::LK_READ && bitCnt == sep_pkg::READ_DUMMY_BIT
        |=> chipSelect |-> (!serialOutEnN && !serialOut))
        else $error("read did not start with a driven zero");
    readMsb_a: assert property (@(posedge serialClockIn) disable iff (linkRst)
        chipSelect && linkState == sep_pkg::LK_READ && bitCnt == sep_pkg::READ_LOAD_BIT && loadReady
        |=> serialOut == $past(selWord[sep_pkg::WORD_W-1]))
        else $error("read data did not start at the top bit");
    dataHandoff_a: assert property (@(posedge serialClockIn) disable iff (linkRst)
        chipSelect && dataLast |=> cmdToggle != $past(cmdToggle))
        else $error("sixteenth data bit did not hand over the write");
    disableCmd_a: assert property (@(posedge mclk) disable iff (srst)
        ce && cmdEvent && cmdHold.opcode == sep_pkg::OP_PROG_DISABLE |=> !progEnable)
        else $error("disable instruction left programming allowed");
    ignoreLocked_a: assert property (@(posedge mclk) disable iff (srst)
        ce && cmdEvent && !progEnable && progState == sep_pkg::PG_IDLE |=> progState == sep_pkg::PG_IDLE [*2])
        else $error("locked programming instruction was accepted");
    burnEnd_a: assert property (@(posedge mclk) disable iff (srst)
        ce && programVoltage && csSync |=> !programVoltage)
        else $error("programming outlived chip select high");
    burnCause_a: assert property (@(posedge mclk) disable iff (srst)
        $rose(programVoltage) |-> $past(wrFire))
        else $error("programming voltage without a programming start");
    standbyBurn_a: assert property (@(posedge mclk) disable iff (srst)
        programVoltage |-> !lowPowerStandby)
        else $error("standby shown while programming");

endmodule // sep_eeprom

// ==== sep_pkg.sv ====
// shared constants and types for the serial 16x16 nonvolatile memory
package sep_pkg;

    // ************************************************************
    // array geometry
    // ************************************************************
    localparam int WORD_W = 16;
    localparam int WORD_COUNT = 16;
    localparam int ADDR_W = 4;
    localparam int OP_W = 4;
    localparam int INSTR_W = 8;
    localparam int PAIR_ADDR_W = 3;
    localparam logic [WORD_W-1:0] ERASED_WORD = 16'hFFFF;

    // ************************************************************
    // opcodes, first two bits for addressed ops, all four otherwise
    // ************************************************************
    localparam logic [1:0] OPHI_READ = 2'h2;
    localparam logic [1:0] OPHI_WRITE = 2'h1;
    localparam logic [1:0] OPHI_ERASE = 2'h3;
    localparam logic [OP_W-1:0] OP_PROG_ENABLE = 4'h3;
    localparam logic [OP_W-1:0] OP_PROG_DISABLE = 4'h0;
    localparam logic [OP_W-1:0] OP_ERASE_ALL = 4'h2;
    localparam logic [OP_W-1:0] OP_WRITE_ALL = 4'h1;

    // ************************************************************
    // bit positions counted on the serial clock after the start bit, restarting from zero after the instruction
    // ************************************************************
    localparam logic [4:0] CMD_PAIR_BIT = 5'h06;
    localparam logic [4:0] CMD_LAST_BIT = 5'h07;
    localparam logic [4:0] DATA_LAST_BIT = 5'h0F;
    localparam logic [4:0] READ_DUMMY_BIT = 5'h00;
    localparam logic [4:0] READ_LOAD_BIT = 5'h01;
    localparam logic [4:0] READ_LAST_BIT = 5'h11;

    // ************************************************************
    // carriers and states
    // ************************************************************
    typedef struct packed {
        logic [OP_W-1:0] opcode;
        logic [ADDR_W-1:0] addr;
        logic [WORD_W-1:0] data;
    } sep_cmd_s;

    typedef struct packed {
        logic en;
        logic all;
        logic erase;
        logic [ADDR_W-1:0] addr;
        logic [WORD_W-1:0] data;
    } sep_wr_s;

    typedef enum logic [1:0] {LK_IDLE, LK_CMD, LK_DATA, LK_READ} sep_link_e;
    typedef enum logic [1:0] {PG_IDLE, PG_ARMED, PG_BURN} sep_prog_e;

endpackage

// ==== sep_mem.sv ====
// sixteen-word cell array with a registered paired read port
`timescale 1ns/100ps
module sep_mem
(
    // clock, reset and enable
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // paired read port
    input wire logic rdEn,
    input wire logic [sep_pkg::PAIR_ADDR_W-1:0] rdPairAddr,
    output logic [2*sep_pkg::WORD_W-1:0] rdPair,
    // programming port
    input wire sep_pkg::sep_wr_s wr
);

    // ************************************************************
    // storage
    // ************************************************************
    logic [sep_pkg::WORD_W-1:0] cells [sep_pkg::WORD_COUNT];
    logic [sep_pkg::WORD_W-1:0] expectWord;
    logic allErased;
    logic wrWord;

    // even word in the upper half, odd word in the lower half
    always_ff @(posedge clk)
    begin
        if (rst)
            rdPair <= '0;
        else if (ce && rdEn)
            rdPair <= {cells[{rdPairAddr, 1'b0}], cells[{rdPairAddr, 1'b1}]};
    end

    // erase sets ones, a write can only pull bits to zero
    always_ff @(posedge clk)
    begin
        if (ce && wr.en)
        begin
            for (int i = 0; i < sep_pkg::WORD_COUNT; i++)
            begin
                if (wr.all || wr.addr == 4'(i))
                begin
                    if (wr.erase)
                        cells[i] <= sep_pkg::ERASED_WORD;
                    else
                        cells[i] <= cells[i] & wr.data;
                end
            end
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    always_comb
    begin
        allErased = 1'b1;
        for (int i = 0; i < sep_pkg::WORD_COUNT; i++)
            allErased = allErased & (cells[i] == sep_pkg::ERASED_WORD);
    end

    assign expectWord = cells[wr.addr] & wr.data;
    assign wrWord = ce && wr.en && !wr.erase && !wr.all;

    eraseWord_a: assert property (@(posedge clk) disable iff (rst)
        ce && wr.en && wr.erase && !wr.all |=> cells[$past(wr.addr)] == sep_pkg::ERASED_WORD)
        else $error("erased word is not all ones");
    eraseAll_a: assert property (@(posedge clk) disable iff (rst)
        ce && wr.en && wr.erase && wr.all |=> allErased)
        else $error("erase all left a word not all ones");
    writeAnd_a: assert property (@(posedge clk) disable iff (rst)
        wrWord |=> cells[$past(wr.addr)] == $past(expectWord))
        else $error("write did not merge data by clearing bits");

endmodule // sep_mem

// ==== sep_ctl_model.sv ====
// controller model that drives the serial link of the memory
`timescale 1ns/100ps
module sep_ctl_model
(
    // serial link
    output logic serialClockIn,
    output logic chipSelect,
    output logic serialIn,
    input wire logic dataLine,
    // read result
    output logic rdDone,
    output logic [16:0] rdWord
);
    initial
    begin
        serialClockIn = 1'b0;
        chipSelect = 1'b0;
        serialIn = 1'b0;
        rdDone = 1'b0;
    end
    // the clock runs only inside ticks and stands still otherwise
    task automatic tick(input logic d);
        serialIn = d;
        #32 serialClockIn = 1'b1;
        #32 serialClockIn = 1'b0;
    endtask
    task automatic idle(input int n);
        repeat (n) tick(1'b0);
    endtask
    task automatic setCs(input logic v);
        chipSelect = v;
    endtask
    // one arming clock, then start, opcode, address and data msb first
    task automatic frame(input logic [24:0] bits, input int n, input bit rd);
        chipSelect = 1'b1;
        tick(1'b0);
        for (int i = n - 1; i >= 0; i--)
            tick(bits[i]);
        if (rd)
        begin
            for (int i = 16; i >= 0; i--)
            begin
                if (i == 15)
                    #200;
                tick(~serialIn);
                rdWord[i] = dataLine;
            end
            tick(~serialIn);
            rdDone = 1'b1;
            #1 rdDone = 1'b0;
        end
    endtask
endmodule // sep_ctl_model

// ==== testbench.sv ====
// self-checking bench for the serial 16x16 memory
`timescale 1ns/100ps
module testbench;
    logic mclk, ce, srst, serialClockIn, chipSelect, serialIn, serialOut, serialOutEnN;
    logic programVoltage, lowPowerStandby, rdDone, enabled;
    logic [16:0] rdWord;
    logic [15:0] shadow [16];
    logic [16:0] expQ [$];
    int mismatches = 0;
    int check_count = 0;
    // a released line reads inverted so that an early release is caught
    wire dataLine = serialOutEnN ? ~serialOut : serialOut;
    sep_eeprom u_sep_eeprom (.mclk(mclk), .ce(ce), .srst(srst), .serialClockIn(serialClockIn),
        .chipSelect(chipSelect), .serialIn(serialIn), .serialOut(serialOut), .serialOutEnN(serialOutEnN),
        .programVoltage(programVoltage), .lowPowerStandby(lowPowerStandby));
    sep_ctl_model u_sep_ctl_model (.serialClockIn(serialClockIn), .chipSelect(chipSelect),
        .serialIn(serialIn), .dataLine(dataLine), .rdDone(rdDone), .rdWord(rdWord));
    initial
    begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    task automatic check(input logic [16:0] seen, input logic [16:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        if (mismatches == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    function automatic logic [3:0] rn4();
        return 4'($urandom);
    endfunction
    task automatic op(input logic [3:0] opc, input logic [3:0] a, input logic [15:0] d);
        logic prog;
        logic wr;
        logic all;
        logic erase;
        prog = opc[2] | (opc[3:2] == 2'b00 && opc[1] != opc[0]);
        wr = opc[3:2] == 2'b01 || opc == 4'h1;
        all = opc[3:2] == 2'b00;
        erase = opc[3] || opc == 4'h2;
        if (opc[3:2] == 2'b10)
            expQ.push_back({1'b0, shadow[a]});
        u_sep_ctl_model.frame(wr ? {1'b1, opc, a, d} : {16'h0000, 1'b1, opc, a}, wr ? 25 : 9, opc[3:2] == 2'b10);
        check({16'h0000, programVoltage}, 17'h0_0000);
        if (prog)
        begin
            u_sep_ctl_model.setCs(1'b0);
            #400; // shortened hold, the device does not time it
            check({15'h0000, programVoltage, lowPowerStandby}, {15'h0000, enabled, !enabled});
            for (int i = 0; i < 16; i++)
                if (enabled && (all || i == a))
                    shadow[i] = erase ? 16'hFFFF : shadow[i] & d;
            u_sep_ctl_model.setCs(1'b1);
            u_sep_ctl_model.tick(1'b0);
            repeat (4) @(negedge mclk);
            check({16'h0000, programVoltage}, 17'h0_0000);
        end
        u_sep_ctl_model.setCs(1'b0);
        repeat (5) @(negedge mclk);
        check({15'h0000, lowPowerStandby, serialOutEnN}, 17'h0_0003);
        if (opc == 4'h3 || opc == 4'h0)
            enabled = opc[0];
    endtask
    task automatic readAll();
        for (int i = 0; i < 16; i++)
            op(4'h8 | (rn4() & 4'h3), 4'(i), 16'h0000);
    endtask
    always @(posedge rdDone)
        check(rdWord, expQ.pop_front());
    initial
    begin
        ce = 1'b1;
        srst = 1'b1;
        enabled = 1'b0;
        void'($urandom(31005));
        fork
            u_sep_ctl_model.idle(3);
        join_none
        repeat (7) @(negedge mclk);
        check({14'h0000, programVoltage, lowPowerStandby, serialOutEnN}, 17'h0_0003);
        @(negedge mclk);
        srst = 1'b0;
        #100;
        u_sep_ctl_model.idle(3);
        // chip select raised while frozen must not reach the system side
        @(negedge mclk) ce = 1'b0;
        u_sep_ctl_model.setCs(1'b1);
        repeat (5) @(negedge mclk);
        check({16'h0000, lowPowerStandby}, 17'h0_0001);
        ce = 1'b1;
        repeat (5) @(negedge mclk);
        check({16'h0000, lowPowerStandby}, 17'h0_0000);
        u_sep_ctl_model.setCs(1'b0);
        repeat (5) @(negedge mclk);
        op(4'h2, rn4(), 16'h0000);
        op(4'h3, rn4(), 16'h0000);
        op(4'h2, rn4(), 16'h0000);
        readAll();
        op(4'h4 | (rn4() & 4'h3), 4'h5, 16'($urandom));
        op(4'h0, rn4(), 16'h0000);
        op(4'hC | (rn4() & 4'h3), 4'h5, 16'h0000);
        op(4'h8, 4'h5, 16'h0000);
        op(4'h3, rn4(), 16'h0000);
        // a start bit on the first selected clock is ignored, else the zeros decode as a disable
        u_sep_ctl_model.setCs(1'b1);
        u_sep_ctl_model.tick(1'b1);
        u_sep_ctl_model.idle(8);
        u_sep_ctl_model.setCs(1'b0);
        repeat (5) @(negedge mclk);
        op(4'h2, rn4(), 16'h0000);
        op(4'h1, rn4(), 16'($urandom));
        op(4'hC | (rn4() & 4'h3), 4'h9, 16'h0000);
        readAll();
        end_of_test();
    end
    initial
    begin
        #300000;
        mismatches++;
        end_of_test();
    end
endmodule // testbench
